// ===== mmap_pkg.sv
package mmap_pkg;

    // ****************************************
    // Segment codes
    // ****************************************
    typedef enum logic [1:0] {
        MMAP_SEG_NONE  = 2'b00,
        MMAP_SEG_FLASH = 2'b01,
        MMAP_SEG_ROM   = 2'b10,
        MMAP_SEG_SRAM  = 2'b11
    } mmap_seg_e;

    // ****************************************
    // Program space map, word addresses
    // ****************************************
    localparam logic [15:0] FLASH_PROG_LO = 16'h0000;
    localparam logic [15:0] FLASH_PROG_HI = 16'h7FFF;
    localparam logic [15:0] ROM_PROG_LO = 16'h8000;
    localparam logic [15:0] ROM_PROG_HI = 16'h8FFF;
    localparam logic [15:0] SRAM_PROG_LO = 16'hA000;
    localparam logic [15:0] SRAM_PROG_HI = 16'hA3FF;
    localparam logic [15:0] USER_RESET_VECTOR = 16'h0000;
    localparam logic [15:0] FETCH_RESET_VALUE = 16'h8000;
    localparam logic [14:0] FLASH_PAGE_WORDS = 15'h4000;

    // ****************************************
    // Data space sizes, words
    // ****************************************
    localparam logic [14:0] SRAM_WORDS = 15'h0400;
    localparam logic [14:0] ROM_WORDS = 15'h1000;
    localparam logic [15:0] DATA_UPPER_BASE = 16'h8000;

    // ****************************************
    // Pointer selects and step codes
    // ****************************************
    localparam logic [1:0] PTR_DP0 = 2'h0;
    localparam logic [1:0] PTR_DP1 = 2'h1;
    localparam logic [1:0] PTR_FRAME = 2'h2;
    localparam logic [1:0] STEP_NONE = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;

    // ****************************************
    // Register byte offsets and fields
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FETCH = 8'h04;
    localparam logic [7:0] REG_DP0 = 8'h08;
    localparam logic [7:0] REG_DP1 = 8'h0C;
    localparam logic [7:0] REG_FBASE = 8'h10;
    localparam logic [7:0] REG_FDISP = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam int CTRL_PAGE_BIT = 0;
    localparam int CTRL_BYTE_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Step a 16-bit pointer by one, wrapping
    function automatic logic [15:0] step16(input logic [15:0] v, input logic [1:0] s);
        step16 = (s == STEP_INC) ? v + 16'h0001 : (s == STEP_DEC) ? v - 16'h0001 : v;
    endfunction : step16

    // Step an 8-bit displacement, wrapping FFh <-> 00h
    function automatic logic [7:0] step8(input logic [7:0] v, input logic [1:0] s);
        step8 = (s == STEP_INC) ? v + 8'h01 : (s == STEP_DEC) ? v - 8'h01 : v;
    endfunction : step8

endpackage : mmap_pkg

// ===== mmap_ptrs.sv
// Pointer bank: two data pointers, frame base and displacement
module mmap_ptrs
    import mmap_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [3:0] sw_we,
    input wire logic [15:0] sw_wdata,
    input wire logic acc_go,
    input wire logic [1:0] acc_sel,
    input wire logic acc_write,
    input wire logic [1:0] acc_step,
    output logic [15:0] dp0_q,
    output logic [15:0] dp1_q,
    output logic [15:0] base_q,
    output logic [7:0] disp_q,
    output logic [15:0] eff_addr
);
    logic [15:0] dp_cur;
    logic [15:0] dp_step;
    logic [7:0] disp_step;
    logic [15:0] dp0_d;
    logic [15:0] dp1_d;
    logic [7:0] disp_d;
    logic pre;

    // Stores step first, loads step afterwards
    assign pre = acc_write;
    assign dp_cur = (acc_sel == PTR_DP1) ? dp1_q : dp0_q;
    assign dp_step = step16(dp_cur, acc_step);
    assign disp_step = step8(disp_q, acc_step); // Base never moves
    // Frame address is an unsigned 16-bit sum
    assign eff_addr = (acc_sel == PTR_FRAME)
        ? base_q + {8'h00, (pre ? disp_step : disp_q)}
        : (pre ? dp_step : dp_cur);

    // Software writes beat a same-cycle step
    assign dp0_d = sw_we[0] ? sw_wdata
        : (acc_go && acc_sel == PTR_DP0) ? dp_step : dp0_q;
    assign dp1_d = sw_we[1] ? sw_wdata
        : (acc_go && acc_sel == PTR_DP1) ? dp_step : dp1_q;
    assign disp_d = sw_we[3] ? sw_wdata[7:0]
        : (acc_go && acc_sel == PTR_FRAME) ? disp_step : disp_q;

    // Pointer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dp0_q <= 16'h0000;
            dp1_q <= 16'h0000;
            base_q <= 16'h0000;
            disp_q <= 8'h00;
        end else if (ce) begin
            dp0_q <= dp0_d;
            dp1_q <= dp1_d;
            disp_q <= disp_d;
            if (sw_we[2]) begin
                base_q <= sw_wdata;
            end
        end
    end

endmodule : mmap_ptrs

// ===== mmap_decode.sv
// Data space decoder, purely combinational
module mmap_decode
    import mmap_pkg::*;
(
    input wire logic [15:0] addr,
    input wire logic byte_mode,
    input wire logic page_sel,
    input wire logic [1:0] exec_seg,
    input wire logic is_write,
    output logic [1:0] tgt_seg,
    output logic [14:0] tgt_word,
    output logic lane_hi,
    output logic refused
);
    logic upper;
    logic [14:0] off;
    logic [14:0] widx;
    logic [1:0] lo_seg;
    logic [1:0] hi_seg;
    logic in_range;

    // Byte mode keeps the low bit as lane select
    assign upper = addr[15];
    assign off = addr[14:0];
    assign widx = byte_mode ? {1'b0, off[14:1]} : off;
    assign lane_hi = byte_mode & addr[0];

    // Segment depends on executing segment and the upper address bit
    assign lo_seg = (exec_seg == MMAP_SEG_SRAM) ? MMAP_SEG_FLASH : MMAP_SEG_SRAM;
    assign hi_seg = (exec_seg == MMAP_SEG_ROM) ? MMAP_SEG_FLASH : MMAP_SEG_ROM;
    assign tgt_seg = upper ? hi_seg : lo_seg;

    // Byte mode shows one flash page, chosen by the page bit
    assign tgt_word = (tgt_seg == MMAP_SEG_FLASH && byte_mode)
        ? (page_sel ? widx | FLASH_PAGE_WORDS : widx) : widx;

    assign in_range = (tgt_seg == MMAP_SEG_FLASH) ? 1'b1
        : (tgt_seg == MMAP_SEG_ROM) ? (widx < ROM_WORDS) : (widx < SRAM_WORDS);

    // Only SRAM takes direct writes; the executing segment is never data
    assign refused = !in_range || (tgt_seg == exec_seg)
        || (is_write && tgt_seg != MMAP_SEG_SRAM);

endmodule : mmap_decode

// ===== mmap_unit.sv
// Register access over AXI4-Lite and the register offsets were left to the implementer.
module mmap_unit
    import mmap_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core fetch port
    input wire logic fetch_req,
    output logic fetch_valid_q,
    output logic [15:0] fetch_addr_q,
    output logic [1:0] fetch_seg_q,
    output logic [14:0] fetch_word_q,
    // Core data port
    input wire logic dacc_req,
    input wire logic dacc_write,
    input wire logic [1:0] dacc_sel,
    input wire logic [1:0] dacc_step,
    input wire logic [15:0] dacc_wdata,
    output logic dacc_refused_q,
    output logic dacc_rvalid_q,
    output logic [15:0] dacc_rdata_q,
    // Memory array strobes
    output logic mem_en_q,
    output logic mem_we_q,
    output logic [1:0] mem_seg_q,
    output logic [14:0] mem_word_q,
    output logic [1:0] mem_be_q,
    output logic [15:0] mem_wdata_q,
    input wire logic [15:0] mem_rdata
);

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_hit;
    logic rd_fire;
    logic rd_hit;
    logic [31:0] rd_word;
    logic [31:0] cur_word;
    logic [15:0] merged;
    logic [1:0] ctrl_q;
    logic [15:0] ip_q;
    logic [1:0] exec_seg_q;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [15:0] fbase;
    logic [7:0] fdisp;
    logic [3:0] ptr_we;

    // Ready while the holding slot is empty and no response waits
    assign s_axi_awready = ce && !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign wr_fire = ce && aw_held_q && w_held_q && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // Address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Read mux over the register map
    function automatic logic [31:0] reg_view(input logic [7:0] a, input logic [15:0] ipv,
                                             input logic [15:0] d0, input logic [15:0] d1,
                                             input logic [15:0] fb, input logic [7:0] fd,
                                             input logic [1:0] ct, input logic [2:0] st);
        case (a)
            REG_CTRL: reg_view = {30'h0000_0000, ct};
            REG_FETCH: reg_view = {16'h0000, ipv};
            REG_DP0: reg_view = {16'h0000, d0};
            REG_DP1: reg_view = {16'h0000, d1};
            REG_FBASE: reg_view = {16'h0000, fb};
            REG_FDISP: reg_view = {24'h00_0000, fd};
            REG_STATUS: reg_view = {29'h0000_0000, st};
            default: reg_view = 32'h0000_0000;
        endcase
    endfunction : reg_view

    // Mapped offsets, used for both channels
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= REG_STATUS) && (a[1:0] == 2'b00);
    endfunction : is_mapped

    assign wr_hit = is_mapped(aw_addr_q) && (aw_addr_q != REG_STATUS);
    assign rd_hit = is_mapped(s_axi_araddr);
    assign rd_word = reg_view(s_axi_araddr, ip_q, dp0, dp1, fbase, fdisp, ctrl_q,
                              {dacc_refused_q, exec_seg_q});
    assign cur_word = reg_view(aw_addr_q, ip_q, dp0, dp1, fbase, fdisp, ctrl_q,
                               {dacc_refused_q, exec_seg_q});
    // Byte strobes merge new bytes into the stored value
    assign merged = {w_strb_q[1] ? w_data_q[15:8] : cur_word[15:8],
                     w_strb_q[0] ? w_data_q[7:0] : cur_word[7:0]};
    assign ptr_we = {wr_fire && wr_hit && aw_addr_q == REG_FDISP,
                     wr_fire && wr_hit && aw_addr_q == REG_FBASE,
                     wr_fire && wr_hit && aw_addr_q == REG_DP1,
                     wr_fire && wr_hit && aw_addr_q == REG_DP0};

    // Responses; status and unmapped writes answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata <= rd_word;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control register: page select and byte mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (ce && wr_fire && wr_hit && aw_addr_q == REG_CTRL) begin
            ctrl_q <= merged[1:0];
        end
    end

    // ****************************************
    // Instruction fetch
    // ****************************************
    logic ip_wr;
    logic [1:0] prog_seg;
    logic [14:0] prog_word;

    // Fixed program map, word addresses only
    assign prog_seg = (ip_q <= FLASH_PROG_HI) ? MMAP_SEG_FLASH
        : (ip_q >= ROM_PROG_LO && ip_q <= ROM_PROG_HI) ? MMAP_SEG_ROM
        : (ip_q >= SRAM_PROG_LO && ip_q <= SRAM_PROG_HI) ? MMAP_SEG_SRAM
        : MMAP_SEG_NONE;
    assign prog_word = (prog_seg == MMAP_SEG_ROM) ? 15'(ip_q - ROM_PROG_LO)
        : (prog_seg == MMAP_SEG_SRAM) ? 15'(ip_q - SRAM_PROG_LO) : ip_q[14:0];
    assign ip_wr = wr_fire && wr_hit && aw_addr_q == REG_FETCH;

    // Counter write beats the step for the next fetch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ip_q <= FETCH_RESET_VALUE;
            exec_seg_q <= MMAP_SEG_ROM;
            fetch_valid_q <= 1'b0;
            fetch_addr_q <= 16'h0000;
            fetch_seg_q <= MMAP_SEG_NONE;
            fetch_word_q <= 15'h0000;
        end else if (ce) begin
            fetch_valid_q <= fetch_req;
            if (ip_wr) begin
                ip_q <= merged;
            end else if (fetch_req) begin
                ip_q <= ip_q + 16'h0001;
            end
            if (fetch_req) begin
                fetch_addr_q <= ip_q;
                fetch_seg_q <= prog_seg;
                fetch_word_q <= prog_word;
                if (prog_seg != MMAP_SEG_NONE) begin
                    exec_seg_q <= prog_seg;
                end
            end
        end
    end

    // ****************************************
    // Data access
    // ****************************************
    logic [15:0] eff_addr;
    logic [1:0] tgt_seg;
    logic [14:0] tgt_word;
    logic lane_hi;
    logic refused;
    logic go;
    logic lane_q;
    logic byte_q;

    // Held back on refusal, pointer steps still apply
    assign go = ce && dacc_req;

    mmap_ptrs u_ptrs (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .sw_we(ptr_we),
        .sw_wdata(merged),
        .acc_go(dacc_req),
        .acc_sel(dacc_sel),
        .acc_write(dacc_write),
        .acc_step(dacc_step),
        .dp0_q(dp0),
        .dp1_q(dp1),
        .base_q(fbase),
        .disp_q(fdisp),
        .eff_addr(eff_addr)
    );

    mmap_decode u_decode (
        .addr(eff_addr),
        .byte_mode(ctrl_q[CTRL_BYTE_BIT]),
        .page_sel(ctrl_q[CTRL_PAGE_BIT]),
        .exec_seg(exec_seg_q),
        .is_write(dacc_write),
        .tgt_seg(tgt_seg),
        .tgt_word(tgt_word),
        .lane_hi(lane_hi),
        .refused(refused)
    );

    // One memory cycle per access; load or store by direction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_en_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_seg_q <= MMAP_SEG_NONE;
            mem_word_q <= 15'h0000;
            mem_be_q <= 2'b00;
            mem_wdata_q <= 16'h0000;
            dacc_refused_q <= 1'b0;
            lane_q <= 1'b0;
            byte_q <= 1'b0;
        end else if (ce) begin
            mem_en_q <= go && !refused;
            mem_we_q <= go && !refused && dacc_write;
            if (go) begin
                dacc_refused_q <= refused;
                mem_seg_q <= tgt_seg;
                mem_word_q <= tgt_word;
                lane_q <= lane_hi;
                byte_q <= ctrl_q[CTRL_BYTE_BIT];
                // Byte writes touch one bank, the other byte is kept
                mem_be_q <= ctrl_q[CTRL_BYTE_BIT] ? {lane_hi, !lane_hi} : 2'b11;
                mem_wdata_q <= ctrl_q[CTRL_BYTE_BIT]
                    ? {dacc_wdata[7:0], dacc_wdata[7:0]} : dacc_wdata;
            end
        end
    end

    // Read data sampled in the memory cycle; byte reads pick a lane
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dacc_rvalid_q <= 1'b0;
            dacc_rdata_q <= 16'h0000;
        end else if (ce) begin
            dacc_rvalid_q <= mem_en_q && !mem_we_q;
            if (mem_en_q && !mem_we_q) begin
                dacc_rdata_q <= byte_q
                    ? {8'h00, (lane_q ? mem_rdata[15:8] : mem_rdata[7:0])}
                    : mem_rdata;
            end
        end
    end

endmodule : mmap_unit

// ===== mmap_unit_assertions.sv
module mmap_unit_chk
    import mmap_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic fetch_req,
    input wire logic fetch_valid_q,
    input wire logic [15:0] fetch_addr_q,
    input wire logic [1:0] fetch_seg_q,
    input wire logic [14:0] fetch_word_q,
    input wire logic dacc_req,
    input wire logic dacc_write,
    input wire logic dacc_refused_q,
    input wire logic dacc_rvalid_q,
    input wire logic mem_en_q,
    input wire logic mem_we_q,
    input wire logic [1:0] mem_seg_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ex_q;
    // ****
    // Helper
    // ****
    // Last mapped fetch segment, one edge late
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ex_q <= MMAP_SEG_ROM;
        end else if (fetch_valid_q && fetch_seg_q != MMAP_SEG_NONE) begin
            ex_q <= fetch_seg_q;
        end
    end
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****
    // Checks
    // ****
    // No register write near the two fetches
    a_fetch_step: assert property (!s_axi_awvalid && !s_axi_wvalid ##1 fetch_req
        && !s_axi_awvalid && !s_axi_wvalid ##1 fetch_req
        |=> fetch_addr_q == $past(fetch_addr_q) + 16'h0001) else $error("no step");
    a_fetch_answer: assert property (fetch_req |=> fetch_valid_q)
        else $error("fetch lost");
    a_fetch_flash: assert property (fetch_valid_q && !fetch_addr_q[15] |->
        fetch_seg_q == MMAP_SEG_FLASH && fetch_word_q == fetch_addr_q[14:0]) else $error("flash");
    a_fetch_rom: assert property (fetch_valid_q && fetch_addr_q[15:12] == 4'h8 |->
        fetch_seg_q == MMAP_SEG_ROM && fetch_word_q == {3'h0, fetch_addr_q[11:0]}) else $error("rom");
    a_fetch_sram: assert property (fetch_valid_q && fetch_addr_q[15:10] == 6'h28 |->
        fetch_seg_q == MMAP_SEG_SRAM && fetch_word_q == {5'h00, fetch_addr_q[9:0]}) else $error("sram");
    a_req_answer: assert property (dacc_req |=> dacc_refused_q != mem_en_q)
        else $error("access unanswered");
    a_mem_cause: assert property (mem_en_q |-> $past(dacc_req))
        else $error("stray strobe");
    a_store_dir: assert property (mem_en_q |-> mem_we_q == $past(dacc_write))
        else $error("wrong direction");
    a_load_data: assert property (dacc_req && !dacc_write ##1 !dacc_refused_q |=> dacc_rvalid_q)
        else $error("load data missing");
    a_write_sram: assert property (mem_en_q && mem_we_q |-> mem_seg_q == MMAP_SEG_SRAM)
        else $error("write off sram");
    a_exec_guard: assert property (mem_en_q |-> mem_seg_q != ex_q)
        else $error("executing segment used as data");
endmodule : mmap_unit_chk
bind mmap_unit mmap_unit_chk chk_u (.*);

// ===== mmap_core_model.sv
// Core side: issues fetches and pointer moves
module mmap_core_model
    import mmap_pkg::*;
(
    input wire logic aclk,
    output logic fetch_req,
    output logic dacc_req,
    output logic dacc_write,
    output logic [1:0] dacc_sel,
    output logic [1:0] dacc_step,
    output logic [15:0] dacc_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        fetch_req = 1'b0;
        dacc_req = 1'b0;
        dacc_write = 1'b0;
        dacc_sel = PTR_DP0;
        dacc_step = STEP_NONE;
        dacc_wdata = 16'h0000;
    end
    // Back-to-back fetches, one per high cycle
    task automatic fetch(input int n);
        @(posedge aclk);
        fetch_req <= 1'b1;
        repeat (n) @(posedge aclk);
        fetch_req <= 1'b0;
    endtask : fetch
    // Load when source, store when destination, optional step
    task automatic access(input logic [1:0] sel, input logic wr, input logic [1:0] st,
            input logic [15:0] wd);
        @(posedge aclk);
        dacc_req <= 1'b1;
        dacc_write <= wr;
        dacc_sel <= sel;
        dacc_step <= st;
        dacc_wdata <= wd;
        @(posedge aclk);
        dacc_req <= 1'b0;
        dacc_wdata <= ~wd; // Released data never repeats
    endtask : access
endmodule : mmap_core_model

// ===== tb_memory_map_unit.sv
module tb_memory_map_unit
    import mmap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, ce;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, fetch_seg_q, dacc_sel, dacc_step, mem_seg_q, mem_be_q;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_en_q, mem_we_q;
    logic fetch_req, fetch_valid_q, dacc_req, dacc_write, dacc_refused_q, dacc_rvalid_q;
    logic [15:0] fetch_addr_q, dacc_wdata, dacc_rdata_q, mem_wdata_q, mem_rdata;
    logic [14:0] fetch_word_q, mem_word_q;
    int errors, samples_checked, cyc;
    // Memory reads back its address, so a wrong word shows
    assign mem_rdata = {mem_en_q, mem_word_q} ^ 16'h5A5A;
    mmap_unit dut_u (.*);
    mmap_core_model core_u (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // Answers sampled mid-cycle, when settled
    task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) chk("bresp", 32'(s_axi_bresp), 32'(er));
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [1:0] er);
        logic ta, tb;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_arready;
            tb = s_axi_rvalid;
            rd = s_axi_rdata;
            if (tb) chk("rresp", 32'(s_axi_rresp), 32'(er));
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tb);
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic mem(input logic [1:0] sg, input logic [14:0] w, input logic rf);
        @(negedge aclk);
        chk("refused", 32'(dacc_refused_q), 32'(rf));
        if (!rf) begin
            chk("seg", 32'(mem_seg_q), 32'(sg));
            chk("word", 32'(mem_word_q), 32'(w));
        end
    endtask : mem
    task automatic dchk(input logic [15:0] p, input logic wr, input logic [1:0] sg,
            input logic [14:0] w, input logic rf);
        axw(REG_DP0, p, RESP_OKAY);
        core_u.access(PTR_DP0, wr, STEP_NONE, 16'hC3C3);
        mem(sg, w, rf);
    endtask : dchk
    task automatic fchk(input logic [15:0] a, input logic [1:0] sg, input logic [14:0] w);
        axw(REG_FETCH, a, RESP_OKAY);
        core_u.fetch(1);
        @(negedge aclk);
        chk("fetch addr", 32'(fetch_addr_q), 32'(a));
        chk("fetch seg", 32'(fetch_seg_q), 32'(sg));
        if (sg != MMAP_SEG_NONE) chk("fetch word", 32'(fetch_word_q), 32'(w));
    endtask : fchk
    // Hang guard; a run needs under 1000 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            complete_run();
        end
    end
    // ****
    // Sequence
    // ****
    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axr(REG_STATUS, RESP_OKAY);
        chk("exec seg", 32'(rd[1:0]), 32'(MMAP_SEG_ROM));
        axr(8'h1C, RESP_SLVERR);
        axw(REG_STATUS, 16'h0003, RESP_SLVERR);
        $display("done: registers");
        fchk(16'h9000, MMAP_SEG_NONE, 15'h0000);
        fchk(16'h4000, MMAP_SEG_FLASH, 15'h4000);
        fchk(16'h7FFF, MMAP_SEG_FLASH, 15'h7FFF);
        fchk(16'hA3FF, MMAP_SEG_SRAM, 15'h03FF);
        fchk(16'h8FFF, MMAP_SEG_ROM, 15'h0FFF);
        fchk(16'h8000, MMAP_SEG_ROM, 15'h0000);
        core_u.fetch(3);
        @(negedge aclk);
        chk("fetch step", 32'(fetch_addr_q), 32'h8003);
        $display("done: program map");
        axw(REG_DP0, 16'h0010, RESP_OKAY);
        core_u.access(PTR_DP0, 1'b0, STEP_INC, 16'h0000);
        mem(MMAP_SEG_SRAM, 15'h0010, 1'b0);
        @(negedge aclk);
        chk("rdata", 32'(dacc_rdata_q), 32'(16'h8010 ^ 16'h5A5A));
        axr(REG_DP0, RESP_OKAY);
        chk("dp0", 32'(rd[15:0]), 32'h0011);
        axw(REG_DP1, 16'h0020, RESP_OKAY);
        core_u.access(PTR_DP1, 1'b1, STEP_INC, 16'hBEEF);
        mem(MMAP_SEG_SRAM, 15'h0021, 1'b0);
        chk("wdata", 32'(mem_wdata_q), 32'h0000BEEF);
        chk("be", 32'(mem_be_q), 32'h3);
        axw(REG_FBASE, 16'h0100, RESP_OKAY);
        axw(REG_FDISP, 16'h00FF, RESP_OKAY);
        core_u.access(PTR_FRAME, 1'b0, STEP_INC, 16'h0000);
        mem(MMAP_SEG_SRAM, 15'h01FF, 1'b0);
        core_u.access(PTR_FRAME, 1'b1, STEP_DEC, 16'h0055);
        mem(MMAP_SEG_SRAM, 15'h01FF, 1'b0);
        axr(REG_FBASE, RESP_OKAY);
        chk("base", 32'(rd[15:0]), 32'h0100);
        $display("done: pointers");
        dchk(16'h8000, 1'b0, MMAP_SEG_FLASH, 15'h0000, 1'b0);
        dchk(16'hFFFF, 1'b0, MMAP_SEG_FLASH, 15'h7FFF, 1'b0);
        dchk(16'h8000, 1'b1, MMAP_SEG_FLASH, 15'h0000, 1'b1);
        dchk(16'h03FF, 1'b1, MMAP_SEG_SRAM, 15'h03FF, 1'b0);
        axw(REG_CTRL, 16'h0002, RESP_OKAY);
        dchk(16'h8003, 1'b0, MMAP_SEG_FLASH, 15'h0001, 1'b0);
        axw(REG_CTRL, 16'h0003, RESP_OKAY);
        dchk(16'h8003, 1'b0, MMAP_SEG_FLASH, 15'h4001, 1'b0);
        chk("be", 32'(mem_be_q), 32'h2);
        axw(REG_CTRL, 16'h0000, RESP_OKAY);
        fchk(16'hA000, MMAP_SEG_SRAM, 15'h0000);
        dchk(16'h0005, 1'b0, MMAP_SEG_FLASH, 15'h0005, 1'b0);
        dchk(16'h8005, 1'b0, MMAP_SEG_ROM, 15'h0005, 1'b0);
        dchk(16'h9000, 1'b0, MMAP_SEG_ROM, 15'h1000, 1'b1);
        fchk(16'h0000, MMAP_SEG_FLASH, 15'h0000);
        dchk(16'h0005, 1'b1, MMAP_SEG_SRAM, 15'h0005, 1'b0);
        dchk(16'h8005, 1'b1, MMAP_SEG_ROM, 15'h0005, 1'b1);
        axr(REG_STATUS, RESP_OKAY);
        chk("status", 32'(rd[2:0]), 32'h5);
        $display("done: data map");
        complete_run();
    end
endmodule : tb_memory_map_unit
